// File: hdl/irqf_pkg.sv
// Constants, register map and types for the peripheral interrupt flag block.
package irqf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths.
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned FLAG_W   = 8;
   localparam int unsigned BYTE_W   = 8;
   localparam int unsigned MODE_W   = 2;
   localparam int unsigned PERIOD_W = 8;
   localparam int unsigned WIDE_W   = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the APB.
   localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_RXDATA = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // Flag bit positions.
   localparam int unsigned BIT_OVF    = 0;
   localparam int unsigned BIT_PERIOD = 1;
   localparam int unsigned BIT_CC     = 2;
   localparam int unsigned BIT_SYNC   = 3;
   localparam int unsigned BIT_TX     = 4;
   localparam int unsigned BIT_RX     = 5;
   localparam int unsigned BIT_CONV   = 6;
   localparam int unsigned BIT_TOP    = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Field masks and reset values.
   localparam logic [FLAG_W-1:0]   STICKY_MASK = 8'h4f;
   localparam logic [FLAG_W-1:0]   IMPL_MASK   = 8'h7f;
   localparam logic [FLAG_W-1:0]   FLAGS_RST   = 8'h00;
   localparam logic [FLAG_W-1:0]   MASK_RST    = 8'h00;
   localparam logic [PERIOD_W-1:0] PERIOD_RST  = 8'hff;
   localparam logic [WIDE_W-1:0]   WIDE_MAX    = 16'hffff;
   localparam logic [WIDE_W-1:0]   WIDE_ZERO   = 16'h0000;
   localparam logic [BYTE_W-1:0]   BYTE_RST    = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Capture/compare operating modes, Gray coded.
   typedef enum logic [MODE_W-1:0] {
      CCP_OFF     = 2'h0,
      CCP_CAPTURE = 2'h1,
      CCP_COMPARE = 2'h3,
      CCP_PWM     = 2'h2
   } irqf_ccp_mode_type;

   // Address decode shared by the write and read paths.
   function automatic logic irqf_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
      return addr == ofs;
   endfunction : irqf_hit

endpackage : irqf_pkg

// File: hdl/irqf_sticky_bit.sv
// One software-writable event flag in which a hardware set wins.
`timescale 1ns/10ps
module irqf_sticky_bit
   import irqf_pkg::*;
(
   input  logic pclk,
   input  logic presetn,
   input  logic set,
   input  logic wr,
   input  logic wdata,
   output logic q
);

   logic q_reg;

   ////////////////////////////////////////////////////////////////////////////
   // The event sets, a software write stores its bit, the event wins a tie.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q_reg <= 1'b0;
      else if (set)
         q_reg <= 1'b1;
      else if (wr)
         q_reg <= wdata;
   end

   assign q = q_reg;

   ////////////////////////////////////////////////////////////////////////////
   // A set in the same cycle as a clearing write leaves the flag set.
   set_wins_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      set && wr && !wdata |=> q_reg)
      else $error("flag lost an event against a clearing write");

endmodule : irqf_sticky_bit

// File: hdl/irqf_wrap_detect.sv
// Detects the wide timer rolling over from all ones to zero.
`timescale 1ns/10ps
module irqf_wrap_detect
   import irqf_pkg::*;
(
   input  logic              pclk,
   input  logic              presetn,
   input  logic [WIDE_W-1:0] count,
   output logic              wrap
);

   logic [WIDE_W-1:0] prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Remember the previous count to see the roll-over step.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev_reg <= WIDE_ZERO;
      else
         prev_reg <= count;
   end

   // The overflow is the step from the top value to zero.
   assign wrap = (prev_reg == WIDE_MAX) && (count == WIDE_ZERO);

endmodule : irqf_wrap_detect

// File: hdl/irqf_top.sv
// APB peripheral interrupt flag register with sticky status and mask.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - Flags set on their event regardless of any enable or global enable.
// - Converter flag, bit 6, sets when conversion ends, software clears it.
// - Receive flag, bit 5, read-only, buffer full, clears on data read.
// - Transmit flag, bit 4, read-only, buffer empty, clears on data write.
// - Sync port flag, bit 3, sets on transfer end, held until cleared.
// - Bit 2 sets on a timer capture in capture mode, held until cleared.
// - Bit 2 sets on compare match in compare mode; unused in PWM mode.
// - Period flag, bit 1, sets when timer equals period register.
// - Overflow flag, bit 0, sets when the wide timer overflows.
// - Bit 7 is unimplemented, reads zero and ignores writes.
module irqf_top
   import irqf_pkg::*;
(
   input  logic                pclk,
   input  logic                presetn,
   input  logic                psel,
   input  logic                penable,
   input  logic                pwrite,
   input  logic [ADDR_W-1:0]   paddr,
   input  logic [DATA_W-1:0]   pwdata,
   output logic [DATA_W-1:0]   prdata,
   output logic                pready,
   output logic                pslverr,
   output logic                irq,
   input  logic                conv_done,
   input  logic                rx_full,
   input  logic [BYTE_W-1:0]   rx_byte,
   output logic                rx_pop,
   input  logic                tx_empty,
   output logic                tx_load,
   output logic [BYTE_W-1:0]   tx_byte,
   input  logic                sync_done,
   input  logic                capture_evt,
   input  logic                compare_evt,
   input  logic [PERIOD_W-1:0] period_count,
   input  logic [WIDE_W-1:0]   wide_count
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [DATA_W-1:0]   prdata_reg;
   logic                pready_reg;
   logic                pslverr_reg;
   logic                irq_reg;
   logic                rx_pop_reg;
   logic                tx_load_reg;
   logic [BYTE_W-1:0]   tx_byte_reg;
   logic                rx_flag_reg;
   logic                tx_flag_reg;
   logic [FLAG_W-1:0]   flags_prev_reg;
   logic [FLAG_W-1:0]   status_reg;
   logic [FLAG_W-1:0]   mask_reg;
   irqf_ccp_mode_type   mode_reg;
   logic [PERIOD_W-1:0] period_reg;
   logic [PERIOD_W-1:0] period_prev_reg;
   logic                acc;
   logic                wr_acc;
   logic                rd_acc;
   logic                hit_flags;
   logic                hit_status;
   logic                hit_mask;
   logic                hit_mode;
   logic                hit_period;
   logic                hit_rx;
   logic                hit_tx;
   logic                hit_any;
   logic                flag_wr;
   logic                period_match;
   logic                overflow;
   logic [FLAG_W-1:0]   sticky_set;
   logic [FLAG_W-1:0]   sticky_q;
   logic [FLAG_W-1:0]   flags_vec;
   logic [FLAG_W-1:0]   flag_events;
   logic [FLAG_W-1:0]   status_clr;
   logic [DATA_W-1:0]   rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode; a transfer completes at the edge that sees pready high.
   assign acc        = psel & penable & pready_reg;
   assign wr_acc     = acc & pwrite;
   assign rd_acc     = acc & ~pwrite;
   assign hit_flags  = irqf_hit(paddr, OFS_FLAGS);
   assign hit_status = irqf_hit(paddr, OFS_STATUS);
   assign hit_mask   = irqf_hit(paddr, OFS_MASK);
   assign hit_mode   = irqf_hit(paddr, OFS_MODE);
   assign hit_period = irqf_hit(paddr, OFS_PERIOD);
   assign hit_rx     = irqf_hit(paddr, OFS_RXDATA);
   assign hit_tx     = irqf_hit(paddr, OFS_TXDATA);
   assign hit_any    = hit_flags | hit_status | hit_mask | hit_mode |
                       hit_period | hit_rx | hit_tx;
   assign flag_wr    = wr_acc & hit_flags;

   ////////////////////////////////////////////////////////////////////////////
   // One wait state: pready rises in the second access cycle for one cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready_reg <= 1'b0;
      else
         pready_reg <= psel & penable & ~pready_reg;
   end

   // Read data and error are captured in the cycle before pready rises.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end
      else if (psel & penable & ~pready_reg)
      begin
         prdata_reg  <= pwrite ? '0 : rd_mux;
         pslverr_reg <= ~hit_any;
      end
      else
      begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end
   end

   // Read multiplexer; narrow registers sit in the low bits.
   always_comb
   begin
      rd_mux = '0;
      if (hit_flags)
         rd_mux[FLAG_W-1:0] = flags_vec & IMPL_MASK;
      else if (hit_status)
         rd_mux[FLAG_W-1:0] = status_reg;
      else if (hit_mask)
         rd_mux[FLAG_W-1:0] = mask_reg;
      else if (hit_mode)
         rd_mux[MODE_W-1:0] = mode_reg;
      else if (hit_period)
         rd_mux[PERIOD_W-1:0] = period_reg;
      else if (hit_rx)
         rd_mux[BYTE_W-1:0] = rx_byte;
      else if (hit_tx)
         rd_mux[BYTE_W-1:0] = tx_byte_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers written by software.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_reg   <= MASK_RST;
         mode_reg   <= CCP_OFF;
         period_reg <= PERIOD_RST;
      end
      else if (wr_acc)
      begin
         if (hit_mask)
            mask_reg <= pwdata[FLAG_W-1:0] & IMPL_MASK;
         if (hit_mode)
            mode_reg <= irqf_ccp_mode_type'(pwdata[MODE_W-1:0]);
         if (hit_period)
            period_reg <= pwdata[PERIOD_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial data side effects: a data read pops, a data write loads.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_pop_reg  <= 1'b0;
         tx_load_reg <= 1'b0;
         tx_byte_reg <= BYTE_RST;
      end
      else
      begin
         rx_pop_reg  <= rd_acc & hit_rx;
         tx_load_reg <= wr_acc & hit_tx;
         if (wr_acc & hit_tx)
            tx_byte_reg <= pwdata[BYTE_W-1:0];
      end
   end

   // Buffer flags follow the level but drop in the cycle of the pop or load.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_flag_reg <= 1'b0;
         tx_flag_reg <= 1'b0;
      end
      else
      begin
         rx_flag_reg <= rx_full & ~rx_pop_reg;
         tx_flag_reg <= tx_empty & ~tx_load_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer event detection.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         period_prev_reg <= '0;
      else
         period_prev_reg <= period_count;
   end

   // A match counts once per new timer value equal to the period.
   assign period_match = (period_count == period_reg) &&
                         (period_count != period_prev_reg);

   irqf_wrap_detect u_wrap (
      .pclk    (pclk),
      .presetn (presetn),
      .count   (wide_count),
      .wrap    (overflow)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Event sources for the sticky flags; no enable gates them.
   always_comb
   begin
      sticky_set             = '0;
      sticky_set[BIT_CONV]   = conv_done;
      sticky_set[BIT_SYNC]   = sync_done;
      sticky_set[BIT_CC]     =
         ((mode_reg == CCP_CAPTURE) & capture_evt) |
         ((mode_reg == CCP_COMPARE) & compare_evt);
      sticky_set[BIT_PERIOD] = period_match;
      sticky_set[BIT_OVF]    = overflow;
   end

   // One flag cell per sticky bit; other positions stay zero here.
   genvar gi;
   generate
      for (gi = 0; gi < FLAG_W; gi++)
      begin : g_flag
         if (STICKY_MASK[gi])
         begin : g_sticky
            irqf_sticky_bit u_bit (
               .pclk    (pclk),
               .presetn (presetn),
               .set     (sticky_set[gi]),
               .wr      (flag_wr),
               .wdata   (pwdata[gi]),
               .q       (sticky_q[gi])
            );
         end
         else
         begin : g_plain
            assign sticky_q[gi] = 1'b0;
         end
      end
   endgenerate

   // Full flag view; the top bit is held at zero.
   always_comb
   begin
      flags_vec          = sticky_q;
      flags_vec[BIT_RX]  = rx_flag_reg;
      flags_vec[BIT_TX]  = tx_flag_reg;
      flags_vec[BIT_TOP] = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: a flag rising sets its bit; writing one clears it.
   assign flag_events = flags_vec & ~flags_prev_reg;
   assign status_clr  = (wr_acc & hit_status) ? pwdata[FLAG_W-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags_prev_reg <= FLAGS_RST;
         status_reg     <= FLAGS_RST;
      end
      else
      begin
         flags_prev_reg <= flags_vec;
         status_reg     <= ((status_reg & ~status_clr) | flag_events) &
                           IMPL_MASK;
      end
   end

   // Level interrupt while any unmasked status bit is set.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(status_reg & mask_reg);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq     = irq_reg;
   assign rx_pop  = rx_pop_reg;
   assign tx_load = tx_load_reg;
   assign tx_byte = tx_byte_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   conv_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      conv_done |=> flags_vec[BIT_CONV])
      else $error("converter flag not set by its event");

   conv_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      flags_vec[BIT_CONV] && !(flag_wr && !pwdata[BIT_CONV])
      |=> flags_vec[BIT_CONV])
      else $error("converter flag dropped without a clearing write");

   rx_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_acc && hit_rx |=> rx_pop_reg ##1 !flags_vec[BIT_RX])
      else $error("receive flag not cleared after a data read");

   tx_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && hit_tx |=> tx_load_reg ##1 !flags_vec[BIT_TX])
      else $error("transmit flag not cleared after a data write");

   sync_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      sync_done |=> flags_vec[BIT_SYNC])
      else $error("sync port flag not set");

   cc_mode_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (mode_reg == CCP_COMPARE && compare_evt) ||
      (mode_reg == CCP_CAPTURE && capture_evt) |=> flags_vec[BIT_CC])
      else $error("capture/compare flag not set in its mode");

   period_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      period_count == period_reg && period_count != $past(period_count)
      |=> flags_vec[BIT_PERIOD])
      else $error("period flag not set on match");

   ovf_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(wide_count) == WIDE_MAX && wide_count == WIDE_ZERO
      |=> flags_vec[BIT_OVF])
      else $error("overflow flag not set on roll-over");

   top_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc && !pwrite && hit_flags |-> prdata_reg[BIT_TOP] == 1'b0)
      else $error("unimplemented flag bit read as one");

   irq_level_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      |(status_reg & mask_reg) |=> irq_reg)
      else $error("interrupt not raised for unmasked status");

endmodule : irqf_top

// File: sim/irqf_periph_model.sv
// Behavioural serial buffer partner that feeds and drains the flag block.
`timescale 1ns/10ps
module irqf_periph_model
   import irqf_pkg::*;
(
   input  logic              pclk,
   input  logic              presetn,
   input  logic              rx_push,
   input  logic [BYTE_W-1:0] rx_push_byte,
   input  logic              rx_pop,
   input  logic              tx_load,
   output logic              rx_full,
   output logic [BYTE_W-1:0] rx_byte,
   output logic              tx_empty
);
   int drain_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer is filled on command and emptied when the block pops it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_full <= 1'b0;
         rx_byte <= 8'h00;
      end
      else if (rx_push)
      begin
         rx_full <= 1'b1;
         rx_byte <= rx_push_byte;
      end
      else if (rx_pop)
      begin
         rx_full <= 1'b0;
         rx_byte <= ~rx_byte; // Stale data is inverted so nobody trusts it.
      end
   end

   // Transmit buffer takes a loaded byte and drains it 20 cycles later.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_empty  <= 1'b1;
         drain_cnt <= 0;
      end
      else if (tx_load)
      begin
         tx_empty  <= 1'b0;
         drain_cnt <= 20;
      end
      else if (drain_cnt == 1)
      begin
         tx_empty  <= 1'b1;
         drain_cnt <= 0;
      end
      else if (drain_cnt > 1)
         drain_cnt <= drain_cnt - 1;
   end
endmodule : irqf_periph_model

// File: sim/testbench.sv
// Self-checking bench for the APB peripheral interrupt flag block.
`timescale 1ns/10ps
module testbench
   import irqf_pkg::*;
;
   typedef struct {logic [DATA_W-1:0] data; logic err;} irqf_note_type;
   logic                pclk = 1'b0;
   logic                presetn = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [ADDR_W-1:0]   paddr = 8'h00;
   logic [DATA_W-1:0]   pwdata = 32'h0;
   logic [DATA_W-1:0]   prdata;
   logic                pready;
   logic                pslverr;
   logic                irq;
   logic                conv_done = 1'b0;
   logic                sync_done = 1'b0;
   logic                capture_evt = 1'b0;
   logic                compare_evt = 1'b0;
   logic [PERIOD_W-1:0] period_count = 8'h00;
   logic [WIDE_W-1:0]   wide_count = 16'h0000;
   logic                rx_full;
   logic [BYTE_W-1:0]   rx_byte;
   logic                rx_pop;
   logic                tx_empty;
   logic                tx_load;
   logic [BYTE_W-1:0]   tx_byte;
   logic                rx_push = 1'b0;
   logic [BYTE_W-1:0]   rx_push_byte = 8'h00;
   logic [BYTE_W-1:0]   cur_val;
   logic [31:0]         seed = 32'h7f22ded3;
   irqf_note_type       note_q[$];
   int                  errors = 0;
   int                  cmp_count = 0;
   int                  cycles = 0;
   int                  bit_of[6] = '{BIT_CONV, BIT_SYNC, BIT_CC, BIT_CC,
                                      BIT_PERIOD, BIT_OVF};
   irqf_ccp_mode_type   neg_mode[6] = '{CCP_OFF, CCP_OFF, CCP_PWM, CCP_PWM,
                                        CCP_CAPTURE, CCP_COMPARE};
   int                  neg_evt[6] = '{2, 3, 2, 3, 3, 2};

   // Free-running 250 MHz clock.
   always #2 pclk = ~pclk;

   irqf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .conv_done(conv_done), .rx_full(rx_full), .rx_byte(rx_byte),
      .rx_pop(rx_pop), .tx_empty(tx_empty), .tx_load(tx_load),
      .tx_byte(tx_byte), .sync_done(sync_done), .capture_evt(capture_evt),
      .compare_evt(compare_evt), .period_count(period_count),
      .wide_count(wide_count));

   irqf_periph_model partner (.pclk(pclk), .presetn(presetn),
      .rx_push(rx_push), .rx_push_byte(rx_push_byte), .rx_pop(rx_pop),
      .tx_load(tx_load), .rx_full(rx_full), .rx_byte(rx_byte),
      .tx_empty(tx_empty));

   ////////////////////////////////////////////////////////////////////////////
   // Closing report, shared by the main sequence and the watchdog.
   task automatic tally_and_finish();
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   // Compares one value and reports a mismatch at once.
   task automatic check(input string what, input logic [DATA_W-1:0] seen,
                        input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Linear feedback shift register step for random data.
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   // One APB transfer; the expected answer is queued for the monitor.
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d,
                      input logic [DATA_W-1:0] e, input logic err);
      note_q.push_back('{e, err});
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so a following call never reassigns these at once.
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      apb(1'b0, a, rnd(), e, 1'b0);
   endtask : rd

   // Pulses one event source, then lets the flag settle.
   task automatic fire(input int k);
      @(posedge pclk);
      case (k)
         0: conv_done <= 1'b1;
         1: sync_done <= 1'b1;
         2: capture_evt <= 1'b1;
         3: compare_evt <= 1'b1;
         4: period_count <= cur_val;
         default: wide_count <= WIDE_MAX;
      endcase
      @(posedge pclk);
      {conv_done, sync_done, capture_evt, compare_evt} <= 4'h0;
      wide_count <= WIDE_ZERO;
      repeat (3) @(posedge pclk);
   endtask : fire

   // Monitor takes the oldest note whenever the slave answers.
   always @(posedge pclk)
   begin
      irqf_note_type note;
      if (pready === 1'b1)
      begin
         note = note_q.pop_front();
         check("prdata", prdata, note.data);
         check("pslverr", {31'h0, pslverr}, {31'h0, note.err});
      end
   end

   // Watchdog against a hung handshake.
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(OFS_FLAGS, 32'h10);
      rd(OFS_STATUS, 32'h10);
      rd(OFS_MASK, 32'h0);
      rd(OFS_MODE, 32'h0);
      rd(OFS_PERIOD, 32'hff);
      check("irq", {31'h0, irq}, 32'h0);
      wr(OFS_STATUS, 32'h10);
      rd(OFS_STATUS, 32'h0);
      wr(OFS_MASK, 32'h7f);
      cur_val = rnd() | 8'h01;
      wr(OFS_PERIOD, {24'h0, cur_val});
      // Every sticky source sets, raises irq and clears by writing zero.
      for (int k = 0; k < 6; k++)
      begin
         if (k == 2)
            wr(OFS_MODE, 32'(CCP_CAPTURE));
         if (k == 3)
            wr(OFS_MODE, 32'(CCP_COMPARE));
         fire(k);
         rd(OFS_FLAGS, 32'h10 | (32'h1 << bit_of[k]));
         rd(OFS_STATUS, 32'h1 << bit_of[k]);
         check("irq", {31'h0, irq}, 32'h1);
         wr(OFS_FLAGS, 32'h0);
         wr(OFS_STATUS, 32'h1 << bit_of[k]);
         rd(OFS_FLAGS, 32'h10);
         check("irq", {31'h0, irq}, 32'h0);
      end
      // Unimplemented and buffer bits ignore writes; flags set while masked.
      wr(OFS_MASK, 32'h0);
      wr(OFS_FLAGS, 32'hff);
      rd(OFS_FLAGS, 32'h5f);
      rd(OFS_STATUS, 32'h4f);
      check("irq", {31'h0, irq}, 32'h0);
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_STATUS, 32'hff);
      // Capture and compare events outside their own mode are dropped.
      for (int m = 0; m < 6; m++)
      begin
         wr(OFS_MODE, 32'(neg_mode[m]));
         fire(neg_evt[m]);
         rd(OFS_FLAGS, 32'h10);
      end
      // A conversion end on the clearing edge keeps the flag.
      fire(0);
      fork
         wr(OFS_FLAGS, 32'h0);
         begin
            repeat (2) @(posedge pclk);
            conv_done <= 1'b1;
            @(posedge pclk);
            conv_done <= 1'b0;
         end
      join
      rd(OFS_FLAGS, 32'h50);
      wr(OFS_FLAGS, 32'h0);
      // Receive flag follows the buffer and clears on a data read.
      cur_val = rnd();
      rx_push <= 1'b1;
      rx_push_byte <= cur_val;
      @(posedge pclk);
      rx_push <= 1'b0;
      repeat (3) @(posedge pclk);
      rd(OFS_FLAGS, 32'h30);
      rd(OFS_RXDATA, {24'h0, cur_val});
      repeat (3) @(posedge pclk);
      rd(OFS_FLAGS, 32'h10);
      // Transmit flag clears on a data write and returns once drained.
      cur_val = rnd();
      wr(OFS_TXDATA, {24'h0, cur_val});
      repeat (3) @(posedge pclk);
      rd(OFS_FLAGS, 32'h0);
      check("tx_byte", {24'h0, tx_byte}, {24'h0, cur_val});
      rd(OFS_TXDATA, {24'h0, cur_val});
      repeat (20) @(posedge pclk);
      rd(OFS_FLAGS, 32'h10);
      // Unmapped places answer with an error and change nothing.
      apb(1'b0, 8'h1c, rnd(), 32'h0, 1'b1);
      apb(1'b1, 8'h20, rnd(), 32'h0, 1'b1);
      rd(OFS_FLAGS, 32'h10);
      repeat (3) @(posedge pclk);
      check("notes left", note_q.size(), 32'h0);
      tally_and_finish();
   end
endmodule : testbench
